/* common/lmeq_pkg.sv */
// Constants, types and decode functions for the lane mode and equalization register bank.
// Assumes byte-wide register accesses delivered by an external serial target engine.
package lmeq_pkg;

	localparam int LANES = 4;
	localparam int EQ_W = 4;
	localparam int CNT_W = 5;
	localparam int PS_W = 2;

	typedef logic [1:0] lmeq_cfg_type;
	typedef logic [EQ_W-1:0] lmeq_eq_type;
	typedef logic [LANES-1:0] lmeq_lanes_type;
	typedef logic [CNT_W-1:0] lmeq_cnt_type;
	typedef logic [PS_W-1:0] lmeq_ps_type;

	// Register offsets
	localparam logic [7:0] ADDR_GEN = 8'h0a;
	localparam logic [7:0] ADDR_EQ_ONE_THREE = 8'h10;
	localparam logic [7:0] ADDR_EQ_ZERO_TWO = 8'h11;
	localparam logic [7:0] ADDR_SNOOP = 8'h12;
	localparam logic [7:0] ADDR_LANE_CTL = 8'h13;

	// Reset values and writable masks
	localparam logic [7:0] GEN_RESET = 8'h01;
	localparam logic [7:0] EQ_RESET = 8'h00;
	localparam logic [7:0] LANE_CTL_RESET = 8'h00;
	localparam logic [7:0] GEN_WR_MASK = 8'h1f;
	localparam logic [7:0] GEN_RSVD_MASK = 8'he0;
	localparam logic [7:0] LANE_CTL_WR_MASK = 8'h8f;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [1:0] RST_SYNC_CLEAR = 2'h0;
	localparam logic SNOOP_RSVD = 1'h0;

	// Field positions
	localparam int GEN_EQ_SRC_BIT = 4;
	localparam int GEN_DP_SRC_BIT = 3;
	localparam int GEN_CFG_HI_BIT = 1;
	localparam int GEN_CFG_LO_BIT = 0;
	localparam int LANE_CTL_MON_OFF_BIT = 7;
	localparam int LANE_CTL_OFF_HI = 3;
	localparam int LANE_CTL_OFF_LO = 0;
	localparam int EQ_HI_MSB = 7;
	localparam int EQ_HI_LSB = 4;
	localparam int EQ_LO_MSB = 3;
	localparam int EQ_LO_LSB = 0;

	// Lane configuration codes
	localparam lmeq_cfg_type CFG_OFF = 2'h0;
	localparam lmeq_cfg_type CFG_USB = 2'h1;
	localparam lmeq_cfg_type CFG_DP4 = 2'h2;
	localparam lmeq_cfg_type CFG_DP2_USB = 2'h3;

	localparam lmeq_lanes_type LANES_ALL = 4'hf;
	localparam lmeq_lanes_type LANES_TWO = 4'h3;
	localparam lmeq_lanes_type LANES_NONE = 4'h0;

	// Sink configuration addresses watched on the AUX channel
	localparam logic [19:0] AUX_ADDR_POWER = 20'h00600;
	localparam logic [19:0] AUX_ADDR_LANES = 20'h00101;
	localparam lmeq_ps_type PS_CLEAR = 2'h0;
	localparam lmeq_ps_type PS_POWER_DOWN = 2'h2;
	localparam lmeq_cnt_type CNT_CLEAR = 5'h00;
	localparam lmeq_cnt_type CNT_TWO = 5'h02;
	localparam logic [1:0] EQ_STRAP_PAD = 2'h0;

	function automatic lmeq_lanes_type mode_lanes(input lmeq_cfg_type cfg);
		lmeq_lanes_type m;
		m = LANES_NONE;
		unique case (cfg)
			CFG_OFF: m = LANES_NONE;
			CFG_USB: m = LANES_NONE;
			CFG_DP4: m = LANES_ALL;
			CFG_DP2_USB: m = LANES_TWO;
		endcase
		return m;
	endfunction

	function automatic logic mode_usb(input lmeq_cfg_type cfg);
		return (cfg == CFG_USB) || (cfg == CFG_DP2_USB);
	endfunction

	function automatic lmeq_eq_type strap_eq(input logic [1:0] strap);
		return {EQ_STRAP_PAD, strap};
	endfunction

	function automatic lmeq_lanes_type count_lanes(input lmeq_cnt_type cnt);
		lmeq_lanes_type m;
		m = LANES_NONE;
		for (int i = 0; i < LANES; i++)
		begin
			m[i] = (cnt > CNT_W'(i));
		end
		return m;
	endfunction

endpackage

/* common/lmeq_state_if.sv */
// Shared configuration and snooped link state between the register bank and its helpers.
// Assumes all users run on clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface lmeq_state_if;
	lmeq_pkg::lmeq_cfg_type lane_config;
	logic dp_src;
	logic monitor_off;
	lmeq_pkg::lmeq_lanes_type per_lane_off;
	lmeq_pkg::lmeq_ps_type pwr_state;
	lmeq_pkg::lmeq_cnt_type lane_count;

	modport regs (output lane_config, dp_src, monitor_off, per_lane_off,
		input pwr_state, lane_count);
	modport snoop (input lane_config, output pwr_state, lane_count);
	modport lanes (input lane_config, dp_src, monitor_off, per_lane_off, pwr_state,
		lane_count);
endinterface
`default_nettype wire

/* design/lmeq_aux_snoop.sv */
// Captures power state and lane count writes seen on the AUX channel.
// Assumes AUX writes arrive decoded, one-cycle valid, synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module lmeq_aux_snoop (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Synchronised reset, active low
	input wire logic aux_wr_valid, // One AUX write seen
	input wire logic [19:0] aux_wr_addr, // Its address
	input wire logic [7:0] aux_wr_data, // Its data
	lmeq_state_if.snoop st // Snooped state out
);
	logic prev_hi_ff;
	logic nxt_prev_hi;
	lmeq_pkg::lmeq_ps_type ps_ff;
	lmeq_pkg::lmeq_ps_type nxt_ps;
	lmeq_pkg::lmeq_cnt_type cnt_ff;
	lmeq_pkg::lmeq_cnt_type nxt_cnt;
	logic hi_fell;

	always_comb
	begin
		nxt_prev_hi = st.lane_config[lmeq_pkg::GEN_CFG_HI_BIT];
		hi_fell = prev_hi_ff && !st.lane_config[lmeq_pkg::GEN_CFG_HI_BIT];
		nxt_ps = ps_ff;
		nxt_cnt = cnt_ff;
		// Clear on falling upper bit; a capture in the same cycle wins
		if (hi_fell)
		begin
			nxt_ps = lmeq_pkg::PS_CLEAR;
			nxt_cnt = lmeq_pkg::CNT_CLEAR;
		end
		if (aux_wr_valid && aux_wr_addr == lmeq_pkg::AUX_ADDR_POWER)
		begin
			nxt_ps = aux_wr_data[lmeq_pkg::PS_W-1:0];
		end
		if (aux_wr_valid && aux_wr_addr == lmeq_pkg::AUX_ADDR_LANES)
		begin
			nxt_cnt = aux_wr_data[lmeq_pkg::CNT_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_hi_ff <= 1'b0;
			ps_ff <= lmeq_pkg::PS_CLEAR;
			cnt_ff <= lmeq_pkg::CNT_CLEAR;
		end
		else
		begin
			prev_hi_ff <= nxt_prev_hi;
			ps_ff <= nxt_ps;
			cnt_ff <= nxt_cnt;
		end
	end

	assign st.pwr_state = ps_ff;
	assign st.lane_count = cnt_ff;
endmodule
`default_nettype wire

/* design/lmeq_config_regs.sv */
// Lane mode and equalization register bank, top level.
// Assumes a byte register port from an external serial target, and synchronous pins.
// How it works
// - Bit 4 of the general register picks strap pins (0) or registers (1) as equalization source.
// - Bit 3 picks whether DisplayPort enable follows the upper config bit (0) or the pin (1).
// - Lane config 00 is all off, 01 USB only, 10 four DP lanes, 11 two DP lanes plus USB.
// - The general register sits at 0x0a and resets to 0x01, so USB only after reset.
// - Four 4-bit lane equalization fields sit at 0x10 and 0x11 and reset to zero.
// - With the strap source chosen, the equalization fields track the strap pins.
// - With the register source chosen, a write to a field changes that lane's equalization.
// - Bits 6:5 of 0x12 hold the snooped power state and are read only.
// - With monitoring on, lanes are powered by the snooped power state.
// - Bits 4:0 of 0x12 hold the snooped lane count and are read only.
// - With monitoring on, only counted lanes that the lane config enables are enabled and the rest powered down.
// - With monitoring off, each lane that the lane config enables follows its own disable bit.
// - A 1 to 0 change of the upper config bit clears the snooped power state.
// - A 1 to 0 change of the upper config bit clears the snooped lane count.
// - Bit 7 of 0x13 resets to 0, keeping monitoring on, and 1 turns it off.
// - Bits 3:0 of 0x13 disable their lanes when 1, only while monitoring is off.
`timescale 1ns/1ns
`default_nettype none
module lmeq_config_regs (
	input wire logic clk_sys, // 125 MHz system clock
	input wire logic rst_n, // Power-on reset, active low
	input wire logic [7:0] reg_addr, // Register offset
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe, one cycle
	input wire logic reg_rd, // Read strobe, one cycle
	output logic [7:0] reg_rdata, // Read data, held
	output logic reg_rvalid, // Read data valid pulse
	input wire logic [1:0] dp_eq_strap_pins, // DisplayPort equalization straps
	input wire logic dp_control_pin, // DisplayPort enable pin
	input wire logic aux_wr_valid, // AUX write observed
	input wire logic [19:0] aux_wr_addr, // AUX write address
	input wire logic [7:0] aux_wr_data, // AUX write data
	output lmeq_pkg::lmeq_eq_type lane0_eq_level, // Lane 0 equalization
	output lmeq_pkg::lmeq_eq_type lane1_eq_level, // Lane 1 equalization
	output lmeq_pkg::lmeq_eq_type lane2_eq_level, // Lane 2 equalization
	output lmeq_pkg::lmeq_eq_type lane3_eq_level, // Lane 3 equalization
	output logic usb_en, // USB path enabled
	output logic dp_en, // DisplayPort function enabled
	output lmeq_pkg::lmeq_lanes_type dp_lane_en // Per-lane DisplayPort enables
);
	logic [1:0] rst_sync_ff;
	logic [1:0] nxt_rst_sync;
	logic rst_sync_n;

	logic [7:0] gen_ff;
	logic [7:0] nxt_gen;
	logic [7:0] eq13_ff;
	logic [7:0] nxt_eq13;
	logic [7:0] eq02_ff;
	logic [7:0] nxt_eq02;
	logic [7:0] lane_ctl_ff;
	logic [7:0] nxt_lane_ctl;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic rvalid_ff;
	logic nxt_rvalid;
	logic [7:0] rd_mux;
	lmeq_pkg::lmeq_eq_type strap_level;
	logic eq_src;

	lmeq_state_if st ();

	// Reset release through two flops
	always_comb
	begin
		nxt_rst_sync = {rst_sync_ff[0], 1'b1};
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_sync_ff <= lmeq_pkg::RST_SYNC_CLEAR;
		end
		else
		begin
			rst_sync_ff <= nxt_rst_sync;
		end
	end

	assign rst_sync_n = rst_sync_ff[1];

	// Register writes
	always_comb
	begin
		eq_src = gen_ff[lmeq_pkg::GEN_EQ_SRC_BIT];
		strap_level = lmeq_pkg::strap_eq(dp_eq_strap_pins);
		nxt_gen = gen_ff;
		nxt_eq13 = eq13_ff;
		nxt_eq02 = eq02_ff;
		nxt_lane_ctl = lane_ctl_ff;
		if (reg_wr && reg_addr == lmeq_pkg::ADDR_GEN)
		begin
			nxt_gen = reg_wdata & lmeq_pkg::GEN_WR_MASK;
		end
		if (reg_wr && reg_addr == lmeq_pkg::ADDR_LANE_CTL)
		begin
			nxt_lane_ctl = reg_wdata & lmeq_pkg::LANE_CTL_WR_MASK;
		end
		if (!eq_src)
		begin
			// Fields mirror the straps; software writes are ignored here
			nxt_eq13 = {strap_level, strap_level};
			nxt_eq02 = {strap_level, strap_level};
		end
		else
		begin
			if (reg_wr && reg_addr == lmeq_pkg::ADDR_EQ_ONE_THREE)
			begin
				nxt_eq13 = reg_wdata;
			end
			if (reg_wr && reg_addr == lmeq_pkg::ADDR_EQ_ZERO_TWO)
			begin
				nxt_eq02 = reg_wdata;
			end
		end
	end

	// Register reads, snooped field is never written
	always_comb
	begin
		unique case (reg_addr)
			lmeq_pkg::ADDR_GEN: rd_mux = gen_ff;
			lmeq_pkg::ADDR_EQ_ONE_THREE: rd_mux = eq13_ff;
			lmeq_pkg::ADDR_EQ_ZERO_TWO: rd_mux = eq02_ff;
			lmeq_pkg::ADDR_SNOOP: rd_mux = {lmeq_pkg::SNOOP_RSVD, st.pwr_state, st.lane_count};
			lmeq_pkg::ADDR_LANE_CTL: rd_mux = lane_ctl_ff;
			default: rd_mux = lmeq_pkg::ZERO_BYTE;
		endcase
		nxt_rvalid = reg_rd;
		nxt_rdata = reg_rd ? rd_mux : rdata_ff;
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			gen_ff <= lmeq_pkg::GEN_RESET;
			eq13_ff <= lmeq_pkg::EQ_RESET;
			eq02_ff <= lmeq_pkg::EQ_RESET;
			lane_ctl_ff <= lmeq_pkg::LANE_CTL_RESET;
			rdata_ff <= lmeq_pkg::ZERO_BYTE;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			gen_ff <= nxt_gen;
			eq13_ff <= nxt_eq13;
			eq02_ff <= nxt_eq02;
			lane_ctl_ff <= nxt_lane_ctl;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign st.lane_config = gen_ff[lmeq_pkg::GEN_CFG_HI_BIT:lmeq_pkg::GEN_CFG_LO_BIT];
	assign st.dp_src = gen_ff[lmeq_pkg::GEN_DP_SRC_BIT];
	assign st.monitor_off = lane_ctl_ff[lmeq_pkg::LANE_CTL_MON_OFF_BIT];
	assign st.per_lane_off = lane_ctl_ff[lmeq_pkg::LANE_CTL_OFF_HI:lmeq_pkg::LANE_CTL_OFF_LO];

	assign reg_rdata = rdata_ff;
	assign reg_rvalid = rvalid_ff;
	assign lane1_eq_level = eq13_ff[lmeq_pkg::EQ_HI_MSB:lmeq_pkg::EQ_HI_LSB];
	assign lane3_eq_level = eq13_ff[lmeq_pkg::EQ_LO_MSB:lmeq_pkg::EQ_LO_LSB];
	assign lane0_eq_level = eq02_ff[lmeq_pkg::EQ_HI_MSB:lmeq_pkg::EQ_HI_LSB];
	assign lane2_eq_level = eq02_ff[lmeq_pkg::EQ_LO_MSB:lmeq_pkg::EQ_LO_LSB];

	lmeq_aux_snoop u_snoop (
		.clk_sys(clk_sys),
		.rst_n(rst_sync_n),
		.aux_wr_valid(aux_wr_valid),
		.aux_wr_addr(aux_wr_addr),
		.aux_wr_data(aux_wr_data),
		.st(st)
	);

	lmeq_lane_ctrl u_lanes (
		.clk_sys(clk_sys),
		.rst_n(rst_sync_n),
		.dp_control_pin(dp_control_pin),
		.st(st),
		.usb_en(usb_en),
		.dp_en(dp_en),
		.dp_lane_en(dp_lane_en)
	);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_sync_n);

	a_eq_strap_track: assert property (
		!eq_src |=> lane0_eq_level == lmeq_pkg::strap_eq($past(dp_eq_strap_pins))
			&& lane3_eq_level == lmeq_pkg::strap_eq($past(dp_eq_strap_pins)))
		else $error("Equalization field does not track strap pins");

	a_eq_sw_write: assert property (
		eq_src && reg_wr && reg_addr == lmeq_pkg::ADDR_EQ_ZERO_TWO
			|=> {lane0_eq_level, lane2_eq_level} == $past(reg_wdata))
		else $error("Software equalization write not applied");

	a_eq_src_select: assert property (
		eq_src && !(reg_wr && reg_addr == lmeq_pkg::ADDR_EQ_ONE_THREE)
			|=> $stable(lane1_eq_level) && $stable(lane3_eq_level))
		else $error("Register equalization moved without a write");

	a_gen_rsvd_zero: assert property (
		reg_rd && reg_addr == lmeq_pkg::ADDR_GEN
			|=> reg_rvalid && (reg_rdata & lmeq_pkg::GEN_RSVD_MASK) == lmeq_pkg::ZERO_BYTE)
		else $error("Reserved general bits read non-zero");

	a_snoop_read_only: assert property (
		reg_wr && reg_addr == lmeq_pkg::ADDR_SNOOP && !aux_wr_valid
			&& !$fell(st.lane_config[lmeq_pkg::GEN_CFG_HI_BIT])
			|=> $stable(st.pwr_state) && $stable(st.lane_count))
		else $error("Snooped field changed by a register write");

	a_power_capture: assert property (
		aux_wr_valid && aux_wr_addr == lmeq_pkg::AUX_ADDR_POWER
			|=> st.pwr_state == $past(aux_wr_data[lmeq_pkg::PS_W-1:0]))
		else $error("Power state not captured from AUX write");

	a_count_capture: assert property (
		aux_wr_valid && aux_wr_addr == lmeq_pkg::AUX_ADDR_LANES
			|=> st.lane_count == $past(aux_wr_data[lmeq_pkg::CNT_W-1:0]))
		else $error("Lane count not captured from AUX write");

	a_fall_clears: assert property (
		$fell(st.lane_config[lmeq_pkg::GEN_CFG_HI_BIT]) && !aux_wr_valid
			|=> st.pwr_state == lmeq_pkg::PS_CLEAR && st.lane_count == lmeq_pkg::CNT_CLEAR)
		else $error("Snooped state not cleared on config fall");

	a_dp_pin_follow: assert property (
		st.dp_src |=> dp_en == $past(dp_control_pin))
		else $error("DisplayPort enable does not follow the pin");

	a_mode_off: assert property (
		st.lane_config == lmeq_pkg::CFG_OFF && !st.dp_src
			|=> !usb_en && !dp_en && dp_lane_en == lmeq_pkg::LANES_NONE)
		else $error("Disabled mode left a path enabled");

	a_power_down: assert property (
		!st.monitor_off && st.pwr_state == lmeq_pkg::PS_POWER_DOWN
			|=> dp_lane_en == lmeq_pkg::LANES_NONE)
		else $error("Lanes enabled during snooped power down");

	a_count_lanes: assert property (
		!st.monitor_off && st.pwr_state != lmeq_pkg::PS_POWER_DOWN && !st.dp_src
			&& st.lane_config == lmeq_pkg::CFG_DP4 && st.lane_count == lmeq_pkg::CNT_TWO
			|=> dp_lane_en == lmeq_pkg::LANES_TWO)
		else $error("Lane enables differ from snooped count");

	a_lane_off_bits: assert property (
		st.monitor_off && !st.dp_src && st.lane_config == lmeq_pkg::CFG_DP4
			|=> dp_lane_en == ~$past(st.per_lane_off))
		else $error("Lane enables ignore per-lane disable bits");

	a_usb_only_mode: assert property (
		st.lane_config == lmeq_pkg::CFG_USB && !st.dp_src
			|=> usb_en && !dp_en && dp_lane_en == lmeq_pkg::LANES_NONE)
		else $error("USB only mode enabled a DisplayPort path");

	a_two_lane_mode: assert property (
		st.lane_config == lmeq_pkg::CFG_DP2_USB && !st.dp_src
			|=> usb_en && dp_en
			&& (dp_lane_en & ~lmeq_pkg::LANES_TWO) == lmeq_pkg::LANES_NONE)
		else $error("Two lane mode enabled an upper lane");

	a_dp_reg_follow: assert property (
		!st.dp_src |=> dp_en == $past(st.lane_config[lmeq_pkg::GEN_CFG_HI_BIT]))
		else $error("DisplayPort enable does not follow the config bit");

	a_eq13_sw_write: assert property (
		eq_src && reg_wr && reg_addr == lmeq_pkg::ADDR_EQ_ONE_THREE
			|=> {lane1_eq_level, lane3_eq_level} == $past(reg_wdata))
		else $error("Lane one and three equalization write not applied");

	a_eq_strap_other: assert property (
		!eq_src |=> lane1_eq_level == lmeq_pkg::strap_eq($past(dp_eq_strap_pins))
			&& lane2_eq_level == lmeq_pkg::strap_eq($past(dp_eq_strap_pins)))
		else $error("Lane one and two equalization does not track straps");

	a_snoop_readback: assert property (
		reg_rd && reg_addr == lmeq_pkg::ADDR_SNOOP
			|=> reg_rvalid && reg_rdata
			== {lmeq_pkg::SNOOP_RSVD, $past(st.pwr_state), $past(st.lane_count)})
		else $error("Snooped field read back wrongly");

	a_lane_ctl_rsvd: assert property (
		reg_rd && reg_addr == lmeq_pkg::ADDR_LANE_CTL
			|=> reg_rvalid && (reg_rdata & ~lmeq_pkg::LANE_CTL_WR_MASK) == lmeq_pkg::ZERO_BYTE)
		else $error("Unused lane control bits read non-zero");

	c_power_down: cover property (
		!st.monitor_off && st.pwr_state == lmeq_pkg::PS_POWER_DOWN
			&& st.lane_count != lmeq_pkg::CNT_CLEAR);
	c_sw_eq_write: cover property (
		eq_src && reg_wr && reg_addr == lmeq_pkg::ADDR_EQ_ONE_THREE);
	c_count_four: cover property (
		aux_wr_valid && aux_wr_addr == lmeq_pkg::AUX_ADDR_LANES && dp_lane_en == lmeq_pkg::LANES_ALL);
	c_fall_clear: cover property (
		$fell(st.lane_config[lmeq_pkg::GEN_CFG_HI_BIT]) && st.lane_count != lmeq_pkg::CNT_CLEAR);
	c_lane_off: cover property (
		st.monitor_off && st.per_lane_off != lmeq_pkg::LANES_NONE && dp_en);
endmodule
`default_nettype wire

/* design/lmeq_lane_ctrl.sv */
// Derives USB enable, DisplayPort enable and per-lane enables from configuration.
// Assumes dp_control_pin is already synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module lmeq_lane_ctrl (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Synchronised reset, active low
	input wire logic dp_control_pin, // DisplayPort enable pin level
	lmeq_state_if.lanes st, // Configuration and snooped state
	output logic usb_en, // USB path enabled
	output logic dp_en, // DisplayPort function enabled
	output lmeq_pkg::lmeq_lanes_type dp_lane_en // Per-lane DisplayPort enables
);
	logic usb_ff;
	logic nxt_usb;
	logic dp_ff;
	logic nxt_dp;
	lmeq_pkg::lmeq_lanes_type lane_ff;
	lmeq_pkg::lmeq_lanes_type nxt_lane;
	lmeq_pkg::lmeq_cfg_type eff_cfg;
	lmeq_pkg::lmeq_lanes_type gate;

	always_comb
	begin
		// Pin or register bit picks the DisplayPort half of the mode
		nxt_dp = st.dp_src ? dp_control_pin : st.lane_config[lmeq_pkg::GEN_CFG_HI_BIT];
		eff_cfg = {nxt_dp, st.lane_config[lmeq_pkg::GEN_CFG_LO_BIT]};
		nxt_usb = lmeq_pkg::mode_usb(eff_cfg);
		if (st.monitor_off)
		begin
			gate = ~st.per_lane_off;
		end
		else
		begin
			gate = lmeq_pkg::count_lanes(st.lane_count)
				& {lmeq_pkg::LANES{st.pwr_state != lmeq_pkg::PS_POWER_DOWN}};
		end
		nxt_lane = lmeq_pkg::mode_lanes(eff_cfg) & gate;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			usb_ff <= 1'b0;
			dp_ff <= 1'b0;
			lane_ff <= lmeq_pkg::LANES_NONE;
		end
		else
		begin
			usb_ff <= nxt_usb;
			dp_ff <= nxt_dp;
			lane_ff <= nxt_lane;
		end
	end

	assign usb_en = usb_ff;
	assign dp_en = dp_ff;
	assign dp_lane_en = lane_ff;
endmodule
`default_nettype wire

/* dv/lane_mode_eq_config_regs_tb.sv */
// Self-checking bench for the lane mode and equalization register bank.
// Assumes the byte register port and decoded AUX writes described for the block.
`timescale 1ns/1ns
`default_nettype none
module lane_mode_eq_config_regs_tb;
	logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, dp_control_pin, usb_en, dp_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, aux_d, aux_wr_data, v, w;
	logic [1:0] dp_eq_strap_pins, ps;
	logic aux_go, aux_wr_valid;
	logic [19:0] aux_a, aux_wr_addr;
	logic [4:0] cnt;
	lmeq_pkg::lmeq_eq_type lane0_eq_level, lane1_eq_level, lane2_eq_level, lane3_eq_level;
	lmeq_pkg::lmeq_lanes_type dp_lane_en;
	int seed = 31;
	int err_count = 0;
	int checks_done = 0;

	lmeq_config_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .dp_eq_strap_pins(dp_eq_strap_pins),
		.dp_control_pin(dp_control_pin), .aux_wr_valid(aux_wr_valid),
		.aux_wr_addr(aux_wr_addr), .aux_wr_data(aux_wr_data),
		.lane0_eq_level(lane0_eq_level), .lane1_eq_level(lane1_eq_level),
		.lane2_eq_level(lane2_eq_level), .lane3_eq_level(lane3_eq_level),
		.usb_en(usb_en), .dp_en(dp_en), .dp_lane_en(dp_lane_en));

	lmeq_aux_source u_aux (.clk_sys(clk_sys), .go(aux_go), .addr(aux_a), .data(aux_d),
		.aux_wr_valid(aux_wr_valid), .aux_wr_addr(aux_wr_addr), .aux_wr_data(aux_wr_data));

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		check({7'h00, reg_rvalid}, 8'h01);
		check(reg_rdata, exp);
	endtask

	task automatic aux(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		aux_go = 1'b1;
		aux_a = a;
		aux_d = d;
		@(posedge clk_sys);
		aux_go = 1'b0;
	endtask

	task automatic settle;
		repeat (3) @(negedge clk_sys);
	endtask

	// Lanes below the count are on unless the power state says power down
	function automatic logic [7:0] exp_lanes(input logic [4:0] n, input logic [1:0] p);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 4; i++)
			m[i] = (n > i) && (p != 2'h2);
		return m;
	endfunction

	initial
	begin
		#100000;
		err_count++;
		test_done;
	end

	initial
	begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		dp_eq_strap_pins = 2'h0;
		dp_control_pin = 1'b0;
		aux_go = 1'b0;
		aux_a = 20'h00000;
		aux_d = 8'h00;
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		rd(8'h0a, 8'h01);
		rd(8'h10, 8'h00);
		rd(8'h11, 8'h00);
		rd(8'h12, 8'h00);
		rd(8'h13, 8'h00);
		rd(8'h55, 8'h00);
		check({6'h00, usb_en, dp_en}, 8'h02);
		// Strap source: writes dropped, fields mirror the pins
		for (int s = 0; s < 4; s++)
		begin
			dp_eq_strap_pins = s[1:0];
			wr(8'h10, 8'h5a);
			settle;
			v = {2'h0, s[1:0], 2'h0, s[1:0]};
			check({lane1_eq_level, lane3_eq_level}, v);
			check({lane0_eq_level, lane2_eq_level}, v);
			rd(8'h10, v);
		end
		wr(8'h0a, 8'h11);
		repeat (6)
		begin
			v = 8'($random(seed));
			w = 8'($random(seed));
			dp_eq_strap_pins = 2'($random(seed));
			wr(8'h10, v);
			wr(8'h11, w);
			settle;
			check({lane1_eq_level, lane3_eq_level}, v);
			check({lane0_eq_level, lane2_eq_level}, w);
			rd(8'h11, w);
		end
		wr(8'h0a, 8'hff);
		rd(8'h0a, 8'h1f);
		wr(8'h12, 8'hff);
		rd(8'h12, 8'h00);
		// Every lane config code, with either DisplayPort enable source
		for (int m = 0; m < 8; m++)
		begin
			dp_control_pin = 1'($random(seed));
			wr(8'h0a, {4'h0, m[2], 1'b0, m[1:0]});
			settle;
			check({6'h00, usb_en, dp_en}, {6'h00, m[0], m[2] ? dp_control_pin : m[1]});
		end
		wr(8'h0a, 8'h02);
		ps = 2'h0;
		cnt = 5'h00;
		repeat (16)
		begin
			v = 8'($random(seed));
			if (v[7])
				ps = v[1:0];
			else
				cnt = v[4:0];
			aux(v[7] ? 20'h00600 : 20'h00101, v);
			aux(20'h00601, 8'hff);
			settle;
			rd(8'h12, {1'b0, ps, cnt});
			check({4'h0, dp_lane_en}, exp_lanes(cnt, ps));
		end
		aux(20'h00600, 8'h01);
		aux(20'h00101, 8'h03);
		ps = 2'h1;
		cnt = 5'h03;
		// Monitoring off: each lane follows its disable bit
		for (int k = 0; k < 16; k++)
		begin
			wr(8'h13, {4'hf, k[3:0]});
			settle;
			rd(8'h13, {4'h8, k[3:0]});
			check({4'h0, dp_lane_en}, {4'h0, ~k[3:0]});
		end
		wr(8'h13, 8'h0f);
		settle;
		check({4'h0, dp_lane_en}, exp_lanes(cnt, ps));
		// Two lanes plus USB keeps only lanes 0 and 1 of the counted set
		wr(8'h0a, 8'h03);
		settle;
		check({4'h0, dp_lane_en}, exp_lanes(cnt, ps) & 8'h03);
		rd(8'h12, 8'h23);
		wr(8'h0a, 8'h00);
		settle;
		rd(8'h12, 8'h00);
		// Second reset in mid-run brings back the power-on values
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		rd(8'h0a, 8'h01);
		rd(8'h13, 8'h00);
		check({6'h00, usb_en, dp_en}, 8'h02);
		test_done;
	end
endmodule
`default_nettype wire

/* dv/lmeq_aux_source.sv */
// Behavioural model of the AUX source whose writes the register bank watches.
// Assumes the bench changes go just after a rising edge, for one cycle per write.
`timescale 1ns/1ns
`default_nettype none
module lmeq_aux_source (
	input wire logic clk_sys, // System clock
	input wire logic go, // Send one write
	input wire logic [19:0] addr, // Write address
	input wire logic [7:0] data, // Write data
	output logic aux_wr_valid, // Write seen on the channel
	output logic [19:0] aux_wr_addr, // Address on the channel
	output logic [7:0] aux_wr_data // Data on the channel
);
	initial
	begin
		aux_wr_valid = 1'b0;
		aux_wr_addr = 20'h00000;
		aux_wr_data = 8'h00;
	end
	// Idle cycles invert stale values so nothing leans on them
	always @(negedge clk_sys)
	begin
		aux_wr_valid <= go;
		aux_wr_addr <= go ? addr : ~aux_wr_addr;
		aux_wr_data <= go ? data : ~aux_wr_data;
	end
endmodule
`default_nettype wire
